// file: dv/dnas_master_model.sv
// field-network master model: link activity and axis mapping
// assumes node_addr and addr_valid come from the drive block
`timescale 1ns/10ps
module dnas_master_model #(
	parameter logic [7:0] AXIS_OFFSET = 8'h10      // per-unit axis offset
) (
	input  wire logic       clk,                   // system clock
	input  wire logic       srst,                  // power-on reset
	input  wire logic [4:0] node_addr,             // drive node address
	input  wire logic       addr_valid,            // drive address accepted
	input  wire logic       link_en,               // bench asks for traffic
	output logic            link_active,           // communication running
	output logic      [7:0] axis_num               // mapped axis number
);
	// only one drive sits on this unit, so its address is unique
	// no traffic to a drive whose address was refused; updated just after the rising edge so
	// the bench, which drives at the falling edge, never races this flop
	always_ff @(posedge clk) begin
		link_active <= link_en & addr_valid & ~srst;
	end
	// node 1 is axis 0, then linear, plus the unit offset
	assign axis_num = addr_valid ? {3'h0, node_addr} - 8'h01 + AXIS_OFFSET : 8'h00;
endmodule // dnas_master_model

// file: dv/dnas_top_tb.sv
// self-checking bench for the node address and status block
// assumes the master model drives link_active
`timescale 1ns/10ps
module dnas_top_tb;
	import dnas_pkg::*;
	logic       clk = 1'b0, srst = 1'b1, link_en = 1'b0, alarm_active = 1'b0, warn_active = 1'b0;
	logic [3:0] tens = 4'h0, units = 4'h0;
	logic [7:0] alarm_code = 8'h00, warn_code = 8'h00, dval = 8'h55, station, axis;
	logic [1:0] dparam = 2'h0;
	logic [4:0] node;
	logic       valid, aalarm, lamp, link;
	logic [6:0] s_t, s_u;
	int         errors = 0, samples_checked = 0;
	always #20 clk = ~clk;
	dnas_top #(.SHOW_CYC(20)) i_dnas_top (.clk(clk), .srst(srst), .tens_digit_switch(tens),
		.units_digit_switch(units), .link_active(link), .alarm_active(alarm_active),
		.alarm_code(alarm_code), .warn_active(warn_active), .warn_code(warn_code),
		.default_display_param(dparam), .default_display_value(dval), .station_addr(station),
		.node_addr(node), .addr_valid(valid), .addr_alarm(aalarm), .comm_status_lamp(lamp),
		.seg_tens(s_t), .seg_units(s_u));
	dnas_master_model #(.AXIS_OFFSET(8'h10)) i_dnas_master_model (.clk(clk), .srst(srst),
		.node_addr(node), .addr_valid(valid), .link_en(link_en), .link_active(link), .axis_num(axis));
	////////////////////////////////////////////////////////////////////////////
	// segment pattern g..a; non-decimal digits show a dash
	function automatic logic [6:0] seg7(input logic [3:0] d);
		logic [6:0] t [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
		return (d > 4'h9) ? 7'h40 : t[d];
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_disp(input logic [7:0] bcd, input logic off);
		chk({1'b0, s_t}, off ? 8'h00 : {1'b0, seg7(bcd[7:4])});
		chk({1'b0, s_u}, off ? 8'h00 : {1'b0, seg7(bcd[3:0])});
	endtask
	// reset stands in for power-up; switches set beforehand
	task automatic power_up(input logic [7:0] sw);
		tens = sw[7:4];
		units = sw[3:0];
		srst = 1'b1;
		repeat (8) @(negedge clk);
		srst = 1'b0;
		repeat (4) @(negedge clk);
	endtask
	task automatic complete_run;
		if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	// both ends and middle of the accepted range, with lamp and axis
	task automatic test_valid;
		logic [7:0] sw [3] = '{8'h01, 8'h17, 8'h31};
		logic [7:0] n;
		for (int i = 0; i < 3; i++) begin
			n = 8'(sw[i][7:4] * 10 + sw[i][3:0]);
			power_up(sw[i]);
			chk(station, n + 8'h40);
			chk({3'h0, node}, n);
			chk({6'h0, valid, aalarm}, 8'h02);
			chk_disp(sw[i], 1'b0);
			chk(axis, n - 8'h01 + 8'h10);
			tens = 4'h9;
			repeat (30) @(negedge clk);
			chk({3'h0, node}, n);
			chk(station, n + 8'h40);
			chk_disp(dval, 1'b0);
			link_en = 1'b1;
			repeat (3) @(negedge clk);
			chk({7'h0, lamp}, 8'h01);
			link_en = 1'b0;
			repeat (3) @(negedge clk);
			chk({7'h0, lamp}, 8'h00);
		end
	endtask
	// zero, just above range and a non-decimal digit
	task automatic test_invalid;
		logic [7:0] sw [3] = '{8'h00, 8'h32, 8'h0a};
		for (int i = 0; i < 3; i++) begin
			power_up(sw[i]);
			chk({6'h0, valid, aalarm}, 8'h01);
			chk(station, 8'h00);
			chk({3'h0, node}, 8'h00);
			chk_disp(8'h82, 1'b0);
		end
	endtask
	// priority of alarm over warning, then each default selection
	task automatic test_display;
		power_up(8'h17);
		// window of 20 cycles plus two pipeline stages: last address edge, then default content
		repeat (18) @(negedge clk);
		chk_disp(8'h17, 1'b0);
		@(negedge clk);
		chk_disp(dval, 1'b0);
		repeat (8) @(negedge clk);
		warn_active = 1'b1;
		warn_code = 8'h34;
		repeat (3) @(negedge clk);
		chk_disp(8'h34, 1'b0);
		alarm_active = 1'b1;
		alarm_code = 8'h21;
		repeat (3) @(negedge clk);
		chk_disp(8'h21, 1'b0);
		warn_active = 1'b0;
		repeat (3) @(negedge clk);
		chk_disp(8'h21, 1'b0);
		alarm_active = 1'b0;
		for (int p = 1; p < 4; p++) begin
			dparam = 2'(p);
			repeat (3) @(negedge clk);
			chk_disp(p == 1 ? 8'h17 : dval, p == 2);
		end
	endtask
	initial begin
		test_valid();
		test_invalid();
		test_display();
		complete_run();
	end
endmodule // dnas_top_tb

// file: shared/dnas_pkg.sv
// constants for the drive node address and status indication block
// assumes a 25 MHz clock and bcd rotary switch inputs
package dnas_pkg;
	localparam logic [7:0] STATION_OFFSET   = 8'h40;       // added to the switch value
	localparam logic [4:0] NODE_MIN         = 5'h01;
	localparam logic [4:0] NODE_MAX         = 5'h1f;       // 31
	localparam logic [7:0] ALARM_NODE_ADDR  = 8'h82;       // bcd code 82
	localparam int         CLK_HZ           = 25000000;
	localparam int         ADDR_SHOW_MS     = 2000;        // address shown this long at power-up
	localparam int         ADDR_SHOW_CYC    = CLK_HZ / 1000 * ADDR_SHOW_MS;
	localparam int         CNT_W            = 26;
	localparam logic [1:0] SEL_DEFAULT      = 2'h0;        // default display parameter codes
	localparam logic [1:0] SEL_STATION      = 2'h1;
	localparam logic [1:0] SEL_BLANK        = 2'h2;

	typedef enum logic [3:0] {
		ST_SAMPLE = 4'h1,
		ST_SHOW   = 4'h2,
		ST_RUN    = 4'h4,
		ST_HOLD   = 4'h8
	} dnas_state_t;
endpackage

// file: src/dnas_seg_enc.sv
// two-digit seven-segment encoder with registered outputs
// assumes a bcd byte input; codes above 9 show a dash
`timescale 1ns/10ps
module dnas_seg_enc (
	input  wire logic       clk,     // system clock
	input  wire logic       srst,    // synchronous reset
	input  wire logic [7:0] bcd,     // two bcd digits
	input  wire logic       blank,   // all segments off
	output logic      [6:0] seg_hi,  // tens digit segments g..a
	output logic      [6:0] seg_lo   // units digit segments g..a
);
	logic [6:0] hi_d;
	logic [6:0] lo_d;

	// one lookup shared by both digits
	function automatic logic [6:0] enc(input logic [3:0] v);
		case (v)
			4'h0: enc = 7'h3f;
			4'h1: enc = 7'h06;
			4'h2: enc = 7'h5b;
			4'h3: enc = 7'h4f;
			4'h4: enc = 7'h66;
			4'h5: enc = 7'h6d;
			4'h6: enc = 7'h7d;
			4'h7: enc = 7'h07;
			4'h8: enc = 7'h7f;
			4'h9: enc = 7'h6f;
			default: enc = 7'h40;
		endcase
	endfunction

	// next segment pattern
	always_comb begin
		hi_d = blank ? 7'h00 : enc(bcd[7:4]);
		lo_d = blank ? 7'h00 : enc(bcd[3:0]);
	end

	// segments come from flops so the top outputs are registered
	always_ff @(posedge clk) begin
		if (srst) begin
			seg_hi <= 7'h00;
			seg_lo <= 7'h00;
		end else begin
			seg_hi <= hi_d;
			seg_lo <= lo_d;
		end
	end
endmodule // dnas_seg_enc

// file: src/dnas_top.sv
// drive node address capture, station address, comm lamp and display select
// assumes srst is the power-on reset and all inputs are synchronous to clk
`timescale 1ns/10ps

// Summary of operation
// - station address equals switch value plus 40h for an accepted address, 00h when the address is refused
// - switch node addresses 1 to 31 are accepted
// - switch value outside 1 to 31 raises alarm code 82
// - switches sampled once after power-on reset, later changes ignored
// - comm lamp lit during communication, dark otherwise
// - display shows node address first, then default display content
// - active alarm code is shown on the display
// - active warning code is shown on the display
module dnas_top
	import dnas_pkg::*;
#(
	parameter int SHOW_CYC = ADDR_SHOW_CYC             // address display time in cycles
) (
	input  wire logic       clk,                       // 25 MHz clock
	input  wire logic       srst,                      // power-on reset, active high
	input  wire logic [3:0] tens_digit_switch,         // tens rotary switch, bcd
	input  wire logic [3:0] units_digit_switch,        // units rotary switch, bcd
	input  wire logic       link_active,               // field-network communication in progress
	input  wire logic       alarm_active,              // external alarm present
	input  wire logic [7:0] alarm_code,                // external alarm code, bcd
	input  wire logic       warn_active,               // warning present
	input  wire logic [7:0] warn_code,                 // warning code, bcd
	input  wire logic [1:0] default_display_param,     // default display selection
	input  wire logic [7:0] default_display_value,     // value for default display content
	output logic      [7:0] station_addr,              // network station address
	output logic      [4:0] node_addr,                 // captured node address
	output logic            addr_valid,                // address accepted
	output logic            addr_alarm,                // node address setting alarm
	output logic            comm_status_lamp,          // communication lamp
	output logic      [6:0] seg_tens,                  // tens digit segments
	output logic      [6:0] seg_units                  // units digit segments
);
	////////////////////////////////////////////////////////////////////////
	// state

	dnas_state_t       st_q, st_d;
	logic [CNT_W-1:0]  cnt_q, cnt_d;
	logic [7:0]        sw_bcd_q, sw_bcd_d;
	logic [4:0]        node_d;
	logic [7:0]        station_d;
	logic              valid_d, alarm_d, lamp_d;
	logic [7:0]        disp_d;
	logic              blank_d;
	logic [7:0]        disp_q;
	logic              blank_q;
	logic [6:0]        bin_sw;

	// bcd pair to binary in seven bits; non-decimal digits may wrap, but the digit check refuses them anyway
	function automatic logic [6:0] bcd2bin(input logic [3:0] t, input logic [3:0] u);
		bcd2bin = ({3'h0, t} * 7'h0a) + {3'h0, u};
	endfunction

	function automatic logic [7:0] bin2bcd(input logic [7:0] b);
		logic [7:0] t;
		t = 8'(b / 8'h0a);
		bin2bcd = {t[3:0], 4'(b % 8'h0a)};
	endfunction

	assign bin_sw = bcd2bin(tens_digit_switch, units_digit_switch);

	////////////////////////////////////////////////////////////////////////
	// address capture and display sequencing

	// address taken once in ST_SAMPLE; no state returns there, so later switch moves are ignored
	always_comb begin
		st_d      = st_q;
		cnt_d     = cnt_q;
		sw_bcd_d  = sw_bcd_q;
		node_d    = node_addr;
		station_d = station_addr;
		valid_d   = addr_valid;
		alarm_d   = addr_alarm;
		case (st_q)
			ST_SAMPLE: begin
				sw_bcd_d = {tens_digit_switch, units_digit_switch};
				cnt_d    = '0;
				st_d     = ST_SHOW;
				// digit codes above 9 are invalid as well
				if (tens_digit_switch <= 4'h9 && units_digit_switch <= 4'h9 &&
				    bin_sw >= 7'(NODE_MIN) && bin_sw <= 7'(NODE_MAX)) begin
					node_d    = bin_sw[4:0];
					station_d = {3'h0, bin_sw[4:0]} + STATION_OFFSET;
					valid_d   = 1'b1;
					alarm_d   = 1'b0;
				end else begin
					node_d    = 5'h00;
					station_d = 8'h00;
					valid_d   = 1'b0;
					alarm_d   = 1'b1;
				end
			end
			ST_SHOW: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q >= CNT_W'(SHOW_CYC - 1))
					st_d = ST_RUN;
			end
			ST_RUN:  st_d = ST_RUN;
			ST_HOLD: st_d = ST_RUN;
			default: st_d = ST_SAMPLE;
		endcase
	end

	// lamp follows link activity
	always_comb lamp_d = link_active;

	// display source, alarm over warning over power-up address over default
	always_comb begin
		blank_d = 1'b0;
		if (addr_alarm)
			disp_d = ALARM_NODE_ADDR;
		else if (alarm_active)
			disp_d = alarm_code;
		else if (warn_active)
			disp_d = warn_code;
		else if (st_q != ST_RUN)
			disp_d = sw_bcd_q;
		else begin
			case (default_display_param)
				SEL_DEFAULT: disp_d = default_display_value;
				SEL_STATION: disp_d = bin2bcd({3'h0, node_addr});
				SEL_BLANK: begin
					disp_d  = 8'h00;
					blank_d = 1'b1;
				end
				default: disp_d = default_display_value;
			endcase
		end
	end

	// registers; the display value is piped one cycle, the encoder adds another
	always_ff @(posedge clk) begin
		if (srst) begin
			st_q             <= ST_SAMPLE;
			cnt_q            <= '0;
			sw_bcd_q         <= 8'h00;
			node_addr        <= 5'h00;
			station_addr     <= 8'h00;
			addr_valid       <= 1'b0;
			addr_alarm       <= 1'b0;
			comm_status_lamp <= 1'b0;
			disp_q           <= 8'h00;
			blank_q          <= 1'b1;
		end else begin
			st_q             <= st_d;
			cnt_q            <= cnt_d;
			sw_bcd_q         <= sw_bcd_d;
			node_addr        <= node_d;
			station_addr     <= station_d;
			addr_valid       <= valid_d;
			addr_alarm       <= alarm_d;
			comm_status_lamp <= lamp_d;
			disp_q           <= disp_d;
			blank_q          <= blank_d;
		end
	end

	dnas_seg_enc u_enc (
		.clk    (clk),
		.srst   (srst),
		.bcd    (disp_q),
		.blank  (blank_q),
		.seg_hi (seg_tens),
		.seg_lo (seg_units)
	);

	////////////////////////////////////////////////////////////////////////
	// checks

	a_station_sum: assert property (@(posedge clk) disable iff (srst)
		addr_valid |-> station_addr == {3'h0, node_addr} + STATION_OFFSET)
		else $error("station address not node plus offset");

	a_node_range: assert property (@(posedge clk) disable iff (srst)
		addr_valid |-> node_addr >= NODE_MIN && node_addr <= NODE_MAX)
		else $error("accepted node address out of range");

	a_alarm_excl: assert property (@(posedge clk) disable iff (srst)
		$past(st_q) == ST_SAMPLE && !$past(srst) |-> addr_alarm != addr_valid)
		else $error("capture gave neither alarm nor valid");

	a_addr_frozen: assert property (@(posedge clk) disable iff (srst)
		st_q == ST_RUN && $past(st_q) == ST_RUN |-> $stable(node_addr) && $stable(addr_alarm))
		else $error("node address changed after capture");

	a_lamp_follow: assert property (@(posedge clk) disable iff (srst)
		link_active ##1 !srst |-> comm_status_lamp)
		else $error("lamp dark during communication");

	a_lamp_dark: assert property (@(posedge clk) disable iff (srst)
		!link_active ##1 !srst |-> !comm_status_lamp)
		else $error("lamp lit without communication");

	a_alarm_shown: assert property (@(posedge clk) disable iff (srst)
		alarm_active && !addr_alarm |=> disp_q == $past(alarm_code))
		else $error("alarm code not displayed");

	a_warn_shown: assert property (@(posedge clk) disable iff (srst)
		warn_active && !alarm_active && !addr_alarm |=> disp_q == $past(warn_code))
		else $error("warning code not displayed");

	a_addr_first: assert property (@(posedge clk) disable iff (srst)
		st_q == ST_SHOW && !alarm_active && !warn_active && !addr_alarm |=> disp_q == sw_bcd_q)
		else $error("power-up address not displayed");
endmodule // dnas_top
